// File: design/ctd_top.sv
// Purpose: Channel 0 trigger detector with Avalon-MM register slave.
// Assumes: One sample per core_clk edge, same clock domain.
// Notes: Levels signed 10 bit, pulse count 16 bit.
// Contract
// - No trigger leaves the block unless OR mask bit 0 is set.
// - Every sample is compared against the levels, one per clock.
// - Mode 1h fires when the samples cross the level upward.
// - Mode 2h fires when the samples cross the level downward.
// - Mode 4h fires on any crossing of the level.
// - Mode 01000001h arms on an upward re-arm crossing, fires upward.
// - Mode 01000002h arms on a downward re-arm crossing, fires downward.
// - A disarmed re-arm detector ignores trigger crossings.
// - Positive re-arm uses level 0 as trigger, level 1 to arm; negative swaps.
// - Mode 04000001h starts the sample counter on an upward crossing.
// - An opposite crossing before the count ends cancels silently.
// - Reaching the programmed count fires a trigger.
// - Counts 2 to 65535 are supported by a 16 bit counter.
// - Levels are signed, -511 to +511, level 0 the upper one.
// - Only one pulse counter exists, shared by one source.
`timescale 1ns/1ns
`default_nettype none

module ctd_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic signed [ctd_pkg::LEVEL_W-1:0] sample_in,
  output logic trig_pulse,
  output logic armed
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [1:0] {
    CTD_ACK_type_IDLE,
    CTD_ACK_type_DONE
  } ctd_ack_type;

  ctd_ack_type ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] mask_q, mask_d;
  logic [31:0] mode_q, mode_d;
  logic signed [ctd_pkg::LEVEL_W-1:0] lvl0_q, lvl0_d;
  logic signed [ctd_pkg::LEVEL_W-1:0] lvl1_q, lvl1_d;
  logic [ctd_pkg::PULSE_W-1:0] pw_q, pw_d;
  logic signed [ctd_pkg::LEVEL_W-1:0] prev_q, prev_d;
  logic prev_ok_q, prev_ok_d;
  logic armed_q, armed_d;
  logic count_on_q, count_on_d;
  logic [ctd_pkg::PULSE_W-1:0] cnt_q, cnt_d;
  logic trig_q, trig_d;
  logic seen_q, seen_d;
  logic wait_q, wait_d;

  logic [15:0] idx;
  logic req;
  logic wr_now;
  logic up0, dn0, up1, dn1;
  logic [1:0] up_x, dn_x;
  logic sel_pos, sel_neg, sel_both, sel_rearm, sel_pw;
  logic fire;

  assign idx = avs_address[17:2];
  assign req = avs_read | avs_write;
  assign wr_now = avs_write & (ack_q == CTD_ACK_type_DONE);

  // ----------------------------------------
  // Byte lane merge
  // ----------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait cycle: read data is latched on the same edge that waitrequest drops,
  // so it is stable at the edge where the master takes it.
  always_comb begin
    logic [31:0] wm;
    wm = 32'h0000_0000;
    ack_d = ack_q;
    rdata_d = rdata_q;
    mask_d = mask_q;
    mode_d = mode_q;
    lvl0_d = lvl0_q;
    lvl1_d = lvl1_q;
    pw_d = pw_q;
    case (ack_q)
      CTD_ACK_type_IDLE: begin
        if (req) begin
          ack_d = CTD_ACK_type_DONE;
          case (idx)
            ctd_pkg::OR_MASK_IDX: rdata_d = mask_q;
            ctd_pkg::MODE_IDX: rdata_d = mode_q;
            ctd_pkg::LEVEL0_IDX: rdata_d = 32'(lvl0_q);
            ctd_pkg::LEVEL1_IDX: rdata_d = 32'(lvl1_q);
            ctd_pkg::PULSE_IDX: rdata_d = {16'h0000, pw_q};
            ctd_pkg::STATUS_IDX: begin
              rdata_d = ctd_pkg::UNMAPPED_RD;
              rdata_d[ctd_pkg::STAT_ARMED_BIT] = armed_q;
              rdata_d[ctd_pkg::STAT_COUNTING_BIT] = count_on_q;
              rdata_d[ctd_pkg::STAT_SEEN_BIT] = seen_q;
            end
            default: rdata_d = ctd_pkg::UNMAPPED_RD;
          endcase
        end
      end
      CTD_ACK_type_DONE: begin
        ack_d = CTD_ACK_type_IDLE;
      end
      default: ack_d = CTD_ACK_type_IDLE;
    endcase
    // Flop copy of the handshake keeps the port glitch free
    wait_d = (ack_d != CTD_ACK_type_DONE);
    if (wr_now) begin
      case (idx)
        ctd_pkg::OR_MASK_IDX: begin
          mask_d = merge(mask_q, avs_writedata, avs_byteenable);
        end
        ctd_pkg::MODE_IDX: begin
          mode_d = merge(mode_q, avs_writedata, avs_byteenable);
        end
        ctd_pkg::LEVEL0_IDX: begin
          wm = merge(32'(lvl0_q), avs_writedata, avs_byteenable);
          lvl0_d = wm[ctd_pkg::LEVEL_W-1:0];
        end
        ctd_pkg::LEVEL1_IDX: begin
          wm = merge(32'(lvl1_q), avs_writedata, avs_byteenable);
          lvl1_d = wm[ctd_pkg::LEVEL_W-1:0];
        end
        ctd_pkg::PULSE_IDX: begin
          wm = merge({16'h0000, pw_q}, avs_writedata, avs_byteenable);
          pw_d = wm[ctd_pkg::PULSE_W-1:0];
        end
        default: wm = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_q <= CTD_ACK_type_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      mask_q <= ctd_pkg::OR_MASK_RST;
      mode_q <= ctd_pkg::MODE_RST;
      lvl0_q <= ctd_pkg::LEVEL_RST;
      lvl1_q <= ctd_pkg::LEVEL_RST;
      pw_q <= ctd_pkg::PULSE_RST;
    end else begin
      ack_q <= ack_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      mask_q <= mask_d;
      mode_q <= mode_d;
      lvl0_q <= lvl0_d;
      lvl1_q <= lvl1_d;
      pw_q <= pw_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------
  // Crossing detection
  // ----------------------------------------
  // Upward means previous below level, current at or above;
  // the two directions are exclusive on one sample.
  for (genvar g = 0; g < 2; g++) begin : g_cross
    // Index 0 watches level 0, index 1 level 1
    logic signed [ctd_pkg::LEVEL_W-1:0] lv;
    assign lv = (g == 0) ? lvl0_q : lvl1_q;
    assign up_x[g] = prev_ok_q && (prev_q < lv) && (sample_in >= lv);
    assign dn_x[g] = prev_ok_q && (prev_q >= lv) && (sample_in < lv);
  end

  always_comb begin
    up0 = up_x[0];
    dn0 = dn_x[0];
    up1 = up_x[1];
    dn1 = dn_x[1];
    sel_pos = mode_q[ctd_pkg::RISING_CROSSING_SELECT];
    sel_neg = mode_q[ctd_pkg::FALLING_CROSSING_SELECT];
    sel_both = mode_q[ctd_pkg::EITHER_CROSSING_SELECT];
    sel_rearm = mode_q[ctd_pkg::ARMING_LEVEL_QUALIFIER];
    sel_pw = mode_q[ctd_pkg::LONG_PULSE_QUALIFIER];
  end

  // ----------------------------------------
  // Trigger modes
  // ----------------------------------------
  // Long pulse takes precedence over re-arm when both are set;
  // only one counter exists, so one source is assumed.
  always_comb begin
    prev_d = sample_in;
    prev_ok_d = 1'b1;
    armed_d = armed_q;
    count_on_d = count_on_q;
    cnt_d = cnt_q;
    fire = 1'b0;
    if (sel_pw) begin
      armed_d = 1'b0;
      if (count_on_q) begin
        // Cancel wins when it lands on the final sample
        if ((sel_pos && dn0) || (!sel_pos && sel_neg && up0)) begin
          count_on_d = 1'b0;
        end else if (cnt_q + 16'h0001 >= pw_q) begin
          fire = 1'b1;
          count_on_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end else if ((sel_pos && up0) || (!sel_pos && sel_neg && dn0)) begin
        count_on_d = 1'b1;
        cnt_d = 16'h0000;
      end
    end else if (sel_rearm) begin
      count_on_d = 1'b0;
      if (sel_pos) begin
        // Trigger on level 0, arm on level 1
        if (armed_q && up0) begin
          fire = 1'b1;
          armed_d = 1'b0;
        end
        if (up1) begin
          armed_d = 1'b1;
        end
      end else if (sel_neg) begin
        // Trigger on level 1, arm on level 0
        if (armed_q && dn1) begin
          fire = 1'b1;
          armed_d = 1'b0;
        end
        if (dn0) begin
          armed_d = 1'b1;
        end
      end else begin
        armed_d = 1'b0;
      end
    end else begin
      armed_d = 1'b0;
      count_on_d = 1'b0;
      fire = (sel_pos && up0)
        || (sel_neg && dn0)
        || (sel_both && (up0 || dn0));
    end
    // Mask gates only the pulse; detector state keeps running
    trig_d = fire && mask_q[ctd_pkg::CH0_OR_ENABLE_BIT];
    seen_d = seen_q || trig_d;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_q <= ctd_pkg::LEVEL_RST;
      prev_ok_q <= 1'b0;
      armed_q <= 1'b0;
      count_on_q <= 1'b0;
      cnt_q <= 16'h0000;
      trig_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      prev_ok_q <= prev_ok_d;
      armed_q <= armed_d;
      count_on_q <= count_on_d;
      cnt_q <= cnt_d;
      trig_q <= trig_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Each port is a flop; no logic sits behind them
  assign trig_pulse = trig_q;
  assign armed = armed_q;

endmodule

`default_nettype wire

// File: inc/ctd_pkg.sv
// Purpose: Constants for the channel trigger detector.
// Assumes: Register indices times four give Avalon byte addresses.
// Notes: Status index is local to this block.
package ctd_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [15:0] OR_MASK_IDX = 16'h9E0C;
  localparam logic [15:0] MODE_IDX = 16'h9EA2;
  localparam logic [15:0] LEVEL0_IDX = 16'hA4D8;
  localparam logic [15:0] LEVEL1_IDX = 16'hA53C;
  localparam logic [15:0] PULSE_IDX = 16'hAC45;
  localparam logic [15:0] STATUS_IDX = 16'hF000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CH0_OR_ENABLE_BIT = 0;
  localparam int RISING_CROSSING_SELECT = 0;
  localparam int FALLING_CROSSING_SELECT = 1;
  localparam int EITHER_CROSSING_SELECT = 2;
  localparam int ARMING_LEVEL_QUALIFIER = 24;
  localparam int LONG_PULSE_QUALIFIER = 26;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_COUNTING_BIT = 1;
  localparam int STAT_SEEN_BIT = 2;
  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam int LEVEL_W = 10;
  localparam int PULSE_W = 16;
  localparam logic [31:0] OR_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 10'h000;
  localparam logic [PULSE_W-1:0] PULSE_RST = 16'h0002;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage

// File: verif/ctd_adc_model.sv
// Purpose: Converter sample source for the detector.
// Assumes: Bench sets the wanted value each clock.
// Notes: Clamps to the usable level span.
`timescale 1ns/1ns
`default_nettype none
module ctd_adc_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic signed [9:0] target,
  output logic signed [9:0] sample_q
);
  logic signed [9:0] sample_d;
  always_comb begin
    sample_d = target;
    if (target < 10'sh201) sample_d = 10'sh201;
  end
  // New sample every clock, never held
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) sample_q <= 10'h000;
    else sample_q <= sample_d;
  end
endmodule
`default_nettype wire

// File: verif/ctd_monitor.sv
// Purpose: Port checker for the trigger detector.
// Assumes: Software writes whole words.
// Notes: Shadows mask, mode and level 0 from bus writes.
`timescale 1ns/1ns
`default_nettype none
module ctd_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic signed [ctd_pkg::LEVEL_W-1:0] sample_in,
  input wire logic trig_pulse,
  input wire logic armed
);
  logic [31:0] mask_q, mode_q;
  logic signed [9:0] lv0_q, prev_q;
  logic up, dn;
  assign up = prev_q < lv0_q && sample_in >= lv0_q;
  assign dn = prev_q >= lv0_q && sample_in < lv0_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask_q <= 32'h0;
      mode_q <= 32'h0;
      lv0_q <= 10'h000;
      prev_q <= 10'h000;
    end else begin
      prev_q <= sample_in;
      if (avs_write && !avs_waitrequest) begin
        case (avs_address[17:2])
          ctd_pkg::OR_MASK_IDX: mask_q <= avs_writedata;
          ctd_pkg::MODE_IDX: mode_q <= avs_writedata;
          ctd_pkg::LEVEL0_IDX: lv0_q <= avs_writedata[9:0];
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wait_ans_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("late bus answer");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long waitrequest gap");
  mask_gate_a:
    assert property (!mask_q[0] |=> !trig_pulse) else $error("masked fire");
  rise_fire_a:
    assert property (mode_q == 32'h1 && mask_q[0] && up |=> trig_pulse)
    else $error("missed rise");
  fall_fire_a:
    assert property (mode_q == 32'h2 && mask_q[0] && dn |=> trig_pulse)
    else $error("missed fall");
  both_fire_a:
    assert property (mode_q == 32'h4 && mask_q[0] && (up || dn)
    |=> trig_pulse) else $error("missed crossing");
  rearm_fire_a:
    assert property (mode_q == 32'h0100_0001 && mask_q[0] && armed && up
    |=> trig_pulse) else $error("armed miss");
  disarm_quiet_a:
    assert property (mode_q == 32'h0100_0001 && !armed |=> !trig_pulse)
    else $error("disarmed fire");
endmodule
bind ctd_top ctd_monitor u_ctd_monitor (.core_clk(core_clk),
  .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .sample_in(sample_in),
  .trig_pulse(trig_pulse), .armed(armed));
`default_nettype wire

// File: verif/ctd_top_tb.sv
// Purpose: Register and trigger tests for the detector.
// Assumes: One request at a time on the bus.
// Notes: Byte lanes all on; partial writes untested.
`timescale 1ns/1ns
`default_nettype none
module ctd_top_tb;
  localparam logic [15:0] MK = ctd_pkg::OR_MASK_IDX;
  localparam logic [15:0] MD = ctd_pkg::MODE_IDX;
  localparam logic [15:0] L0 = ctd_pkg::LEVEL0_IDX;
  localparam logic [15:0] PW = ctd_pkg::PULSE_IDX;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [17:0] avs_address = 18'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, trig_pulse, armed;
  logic signed [9:0] tgt = 10'h3EC;
  logic signed [9:0] sample_in;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_trig = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (trig_pulse === 1'b1) n_trig <= n_trig + 1;
  ctd_adc_model u_ctd_adc_model (.core_clk(core_clk), .reset(reset),
    .target(tgt), .sample_q(sample_in));
  ctd_top u_ctd_top (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_in(sample_in),
    .trig_pulse(trig_pulse), .armed(armed));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low
  task automatic bus(input logic rd, input logic [15:0] a,
                     input logic [31:0] d);
    avs_address <= {a, 2'b00};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic seq(input int v[8], input int exp);
    int n0;
    n0 = n_trig;
    foreach (v[i]) begin
      tgt <= v[i][9:0];
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    chk(n_trig - n0, exp);
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(MK, 32'h0);
    rd(MD, 32'h0);
    rd(PW, 32'h2);
    rd(16'h0001, 32'h0);
    bus(1'b0, PW, 32'h0001_FFFF);
    rd(PW, 32'h0000_FFFF);
    bus(1'b0, L0, 32'hFFFF_FFFB);
    rd(L0, 32'hFFFF_FFFB);
    bus(1'b0, ctd_pkg::LEVEL1_IDX, 32'hFFFF_FF9C);
    bus(1'b0, MD, 32'h4);
    seq('{-20, 20, -20, 20, -20, -20, -20, -20}, 0);
    bus(1'b0, MK, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, MD, 32'h1 << i);
      seq('{-20, 20, -20, 20, -20, -20, -20, -20}, i == 2 ? 4 : 2);
    end
    bus(1'b0, MD, 32'h0100_0001);
    seq('{-20, 20, -20, 20, -20, -20, -20, -20}, 0);
    seq('{-200, -20, -20, -20, -20, -20, -20, -20}, 0);
    chk({31'h0, armed}, 32'h1);
    seq('{-200, -20, 20, -20, 20, -20, -20, -20}, 1);
    chk({31'h0, armed}, 32'h0);
    bus(1'b0, MD, 32'h0100_0002);
    seq('{20, -20, -200, -20, -200, -200, -200, -200}, 1);
    bus(1'b0, PW, 32'h3);
    bus(1'b0, MD, 32'h0400_0001);
    seq('{-20, 20, 20, -20, -20, -20, -20, -20}, 0);
    seq('{20, 20, 20, 20, 20, 20, 20, -20}, 1);
    rd(ctd_pkg::STATUS_IDX, 32'h1 << ctd_pkg::STAT_SEEN_BIT);
    report_and_stop;
  end
  // Tests need under 40 us; ten times that cuts a hang
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
